// [verilog/dsi_top.sv]
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module dsi_top (
   input wire logic mclk, // System clock, 50 MHz.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic scl_in, // Serial clock pin level.
   input wire logic sda_in, // Serial data pin level.
   output logic sda_out, // Serial data drive value, always low.
   output logic sda_oe, // Serial data pull-low enable.
   input wire logic supply_good, // Undervoltage lockout released.
   input wire logic addr_sel, // Address select pin.
   input wire logic overload_one, // Channel one overload.
   input wire logic overload_two, // Channel two overload.
   input wire logic overtemp, // Thermal shutdown active.
   output logic [5:0] cfg_one, // Channel one configuration.
   output logic [4:0] cfg_two, // Channel two configuration.
   input wire logic [1:0] reg_addr, // Register port address.
   input wire logic [7:0] reg_wdata, // Register port write data.
   input wire logic reg_wr, // Register write strobe.
   input wire logic reg_rd, // Register read strobe.
   output logic [7:0] reg_rdata, // Read data, cycle after strobe.
   output logic irq // Interrupt, active high.
);

   dsi_core_if cif ();
   dsi_pkg::dsi_state_t state_ff;
   dsi_pkg::dsi_state_t nxt_state;
   logic scl_prev_ff;
   logic sda_prev_ff;
   logic [2:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic byte_full_ff;
   logic rw_ff;
   logic acked_ff;
   logic sel_ff;
   logic [dsi_pkg::CFG1_W-1:0] cfg_one_ff;
   logic [dsi_pkg::CFG2_W-1:0] cfg_two_ff;
   logic [2:0] flag_prev_ff;
   logic [7:0] reg_rdata_ff;
   logic scl_s;
   logic sda_s;
   logic good_s;
   logic asel_s;
   logic ovl1_s;
   logic ovl2_s;
   logic otemp_s;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic addr_hit;
   logic wr_commit;
   logic [7:0] rd_byte;

   // ***************************************************************
   // Pin synchronisation and interrupt block
   // ***************************************************************
   assign cif.pin_raw = {overtemp, overload_two, overload_one, addr_sel,
      supply_good, sda_in, scl_in};

   dsi_sync u_sync (
      .mclk (mclk),
      .srst (srst),
      .pins (cif.syn)
   );

   dsi_irq u_irq (
      .mclk (mclk),
      .srst (srst),
      .ev (cif.irq),
      .irq (irq)
   );

   assign scl_s = cif.pin_sync[dsi_pkg::PIN_SCL];
   assign sda_s = cif.pin_sync[dsi_pkg::PIN_SDA];
   assign good_s = cif.pin_sync[dsi_pkg::PIN_GOOD];
   assign asel_s = cif.pin_sync[dsi_pkg::PIN_ASEL];
   assign ovl1_s = cif.pin_sync[dsi_pkg::PIN_OVL1];
   assign ovl2_s = cif.pin_sync[dsi_pkg::PIN_OVL2];
   assign otemp_s = cif.pin_sync[dsi_pkg::PIN_OTEMP];

   // ***************************************************************
   // Bus condition detection
   // ***************************************************************
   // Previous synchronised levels give the edges of clock and data.
   always_ff @(posedge mclk) begin
      if (srst) begin
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end else begin
         scl_prev_ff <= scl_s;
         sda_prev_ff <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_prev_ff;
   assign scl_fall = ~scl_s & scl_prev_ff;
   // Start and stop are data edges while the clock stays high.
   assign start_seen = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
   assign stop_seen = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

   // The select pin supplies the low address bit.
   assign addr_hit = (shift_ff[7:1] ==
      (asel_s ? dsi_pkg::ADDR_PIN_HIGH : dsi_pkg::ADDR_PIN_LOW));

   // Read byte: top bit names the register, low bits carry live flags.
   always_comb begin
      if (sel_ff) begin
         rd_byte = {1'b1, cfg_two_ff, otemp_s, ovl2_s};
      end else begin
         rd_byte = {1'b0, cfg_one_ff, ovl1_s};
      end
   end

   // ***************************************************************
   // Serial engine
   // ***************************************************************
   // Next state; start and stop override any bit-level progress.
   always_comb begin
      nxt_state = state_ff;
      if (!good_s) begin
         nxt_state = dsi_pkg::ST_IDLE;
      end else if (start_seen) begin
         nxt_state = dsi_pkg::ST_ADDR;
      end else if (stop_seen) begin
         nxt_state = dsi_pkg::ST_IDLE;
      end else if (scl_fall) begin
         unique case (state_ff)
            dsi_pkg::ST_IDLE, dsi_pkg::ST_IGNORE: begin
               nxt_state = state_ff;
            end
            dsi_pkg::ST_ADDR: begin
               if (byte_full_ff) begin
                  nxt_state = addr_hit ? dsi_pkg::ST_ADDR_ACK
                     : dsi_pkg::ST_IGNORE;
               end
            end
            dsi_pkg::ST_ADDR_ACK: begin
               nxt_state = rw_ff ? dsi_pkg::ST_RD_DATA
                  : dsi_pkg::ST_WR_DATA;
            end
            dsi_pkg::ST_WR_DATA: begin
               if (byte_full_ff) begin
                  nxt_state = dsi_pkg::ST_WR_ACK;
               end
            end
            dsi_pkg::ST_WR_ACK: begin
               nxt_state = dsi_pkg::ST_IGNORE;
            end
            dsi_pkg::ST_RD_DATA: begin
               if (bit_cnt_ff == dsi_pkg::LAST_BIT) begin
                  nxt_state = dsi_pkg::ST_RD_ACK;
               end
            end
            dsi_pkg::ST_RD_ACK: begin
               nxt_state = acked_ff ? dsi_pkg::ST_RD_DATA
                  : dsi_pkg::ST_IGNORE;
            end
            default: begin
               nxt_state = dsi_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         state_ff <= dsi_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Bit counter and shift register; receive on rise, send on fall.
   always_ff @(posedge mclk) begin
      if (srst) begin
         bit_cnt_ff <= 3'h0;
         shift_ff <= 8'h00;
         byte_full_ff <= 1'b0;
      end else if (start_seen) begin
         bit_cnt_ff <= 3'h0;
         byte_full_ff <= 1'b0;
      end else if (scl_rise && (state_ff == dsi_pkg::ST_ADDR ||
            state_ff == dsi_pkg::ST_WR_DATA)) begin
         shift_ff <= {shift_ff[6:0], sda_s};
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
         byte_full_ff <= (bit_cnt_ff == dsi_pkg::LAST_BIT);
      end else if (scl_fall) begin
         byte_full_ff <= 1'b0;
         if (nxt_state == dsi_pkg::ST_RD_DATA &&
               state_ff != dsi_pkg::ST_RD_DATA) begin
            shift_ff <= rd_byte;
            bit_cnt_ff <= 3'h0;
         end else if (state_ff == dsi_pkg::ST_RD_DATA) begin
            shift_ff <= {shift_ff[6:0], 1'b0};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
         end else if (state_ff == dsi_pkg::ST_ADDR_ACK) begin
            bit_cnt_ff <= 3'h0;
         end
      end
   end

   // Direction bit is the last address bit received.
   always_ff @(posedge mclk) begin
      if (srst) begin
         rw_ff <= 1'b0;
      end else if (state_ff == dsi_pkg::ST_ADDR && scl_fall &&
            byte_full_ff) begin
         rw_ff <= shift_ff[0];
      end
   end

   // The master's ninth bit: low means another byte is wanted.
   always_ff @(posedge mclk) begin
      if (srst) begin
         acked_ff <= 1'b0;
      end else if (state_ff == dsi_pkg::ST_RD_ACK && scl_rise) begin
         acked_ff <= ~sda_s;
      end
   end

   // Pull low for acknowledges and for zero data bits only; the line
   // is released in every other state, so a nack leaves it free.
   assign sda_out = 1'b0;
   assign sda_oe = good_s & ((state_ff == dsi_pkg::ST_ADDR_ACK) |
      (state_ff == dsi_pkg::ST_WR_ACK) |
      ((state_ff == dsi_pkg::ST_RD_DATA) & ~shift_ff[7]));

   // ***************************************************************
   // System registers
   // ***************************************************************
   assign wr_commit = (state_ff == dsi_pkg::ST_WR_DATA) & scl_fall &
      byte_full_ff & good_s & ~start_seen & ~stop_seen;

   // Held at zero without supply, so every enable bit starts low and
   // the master can raise it once the rest of the channel is valid.
   always_ff @(posedge mclk) begin
      if (srst || !good_s) begin
         cfg_one_ff <= dsi_pkg::CFG1_RST;
         cfg_two_ff <= dsi_pkg::CFG2_RST;
         sel_ff <= 1'b0;
      end else if (wr_commit) begin
         sel_ff <= shift_ff[dsi_pkg::SEL_BIT];
         if (shift_ff[dsi_pkg::SEL_BIT]) begin
            cfg_two_ff <= shift_ff[dsi_pkg::CFG2_LSB +:
               dsi_pkg::CFG2_W];
         end else begin
            cfg_one_ff <= shift_ff[dsi_pkg::CFG1_LSB +:
               dsi_pkg::CFG1_W];
         end
      end
   end

   assign cfg_one = cfg_one_ff;
   assign cfg_two = cfg_two_ff;

   // ***************************************************************
   // Software register port and events
   // ***************************************************************
   // Previous flag levels turn rising protection flags into events.
   always_ff @(posedge mclk) begin
      if (srst) begin
         flag_prev_ff <= 3'h0;
      end else begin
         flag_prev_ff <= {otemp_s, ovl2_s, ovl1_s};
      end
   end

   assign cif.evt[dsi_pkg::EVT_OVL1] = ovl1_s & ~flag_prev_ff[0];
   assign cif.evt[dsi_pkg::EVT_OVL2] = ovl2_s & ~flag_prev_ff[1];
   assign cif.evt[dsi_pkg::EVT_OTEMP] = otemp_s & ~flag_prev_ff[2];
   assign cif.evt[dsi_pkg::EVT_WRITE] = wr_commit;
   assign cif.stat_clr = reg_rd & (reg_addr == dsi_pkg::REG_STATUS);
   assign cif.mask_wr = reg_wr & (reg_addr == dsi_pkg::REG_MASK);
   assign cif.mask_wdata = reg_wdata[dsi_pkg::EVT_W-1:0];

   // Read data stand for the one cycle after the read strobe.
   always_ff @(posedge mclk) begin
      if (srst || !reg_rd) begin
         reg_rdata_ff <= 8'h00;
      end else begin
         unique case (reg_addr)
            dsi_pkg::REG_CFG1: reg_rdata_ff <= {2'h0, cfg_one_ff};
            dsi_pkg::REG_CFG2: reg_rdata_ff <= {3'h0, cfg_two_ff};
            dsi_pkg::REG_STATUS: reg_rdata_ff <= {4'h0, cif.status};
            dsi_pkg::REG_MASK: reg_rdata_ff <= {4'h0, cif.mask};
         endcase
      end
   end

   assign reg_rdata = reg_rdata_ff;

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   a_regs_held_zero: assert property (!good_s |=>
      (cfg_one_ff == dsi_pkg::CFG1_RST && cfg_two_ff == dsi_pkg::CFG2_RST))
      else $error("registers not zero without supply");

   a_quiet_no_supply: assert property (!good_s |=>
      (!sda_oe && state_ff == dsi_pkg::ST_IDLE))
      else $error("bus answered without supply");

   a_addr_miss_ignored: assert property (
      (state_ff == dsi_pkg::ST_ADDR && byte_full_ff && scl_fall &&
      good_s && !start_seen && !stop_seen && !addr_hit)
      |=> (state_ff == dsi_pkg::ST_IGNORE && !sda_oe))
      else $error("foreign address acknowledged");

   a_read_enters: assert property (
      (state_ff == dsi_pkg::ST_ADDR_ACK && rw_ff && scl_fall && good_s &&
      !start_seen && !stop_seen) |=> (state_ff == dsi_pkg::ST_RD_DATA &&
      shift_ff == $past(rd_byte)))
      else $error("read mode not entered");

   a_msb_first_shift: assert property (
      (state_ff == dsi_pkg::ST_RD_DATA && scl_fall && good_s &&
      !start_seen && !stop_seen) |=>
      (shift_ff[7] == $past(shift_ff[6])))
      else $error("read bit order wrong");

   a_ack_next_byte: assert property (
      (state_ff == dsi_pkg::ST_RD_ACK && acked_ff && scl_fall && good_s &&
      !start_seen && !stop_seen) |=> (state_ff == dsi_pkg::ST_RD_DATA &&
      bit_cnt_ff == 3'h0))
      else $error("acknowledge did not restart byte");

   a_nack_releases: assert property (
      (state_ff == dsi_pkg::ST_RD_ACK && !acked_ff && scl_fall && good_s &&
      !start_seen) |=> !sda_oe [*3])
      else $error("data line held after nack");

   a_flag_one_live: assert property (
      (state_ff == dsi_pkg::ST_ADDR_ACK && rw_ff && !sel_ff && scl_fall &&
      good_s && !start_seen && !stop_seen) |=>
      (shift_ff[dsi_pkg::OVL_BIT] == $past(ovl1_s)))
      else $error("overload flag not live");

   a_otemp_live: assert property (
      (state_ff == dsi_pkg::ST_ADDR_ACK && rw_ff && sel_ff && scl_fall &&
      good_s && !start_seen && !stop_seen) |=>
      (shift_ff[dsi_pkg::OTEMP_BIT] == $past(otemp_s)))
      else $error("over-temperature flag not live");

   a_write_stored: assert property (wr_commit &&
      !shift_ff[dsi_pkg::SEL_BIT] |=> (cfg_one_ff ==
      $past(shift_ff[dsi_pkg::CFG1_LSB +: dsi_pkg::CFG1_W]) && !sel_ff))
      else $error("written value not stored");

   c_read_acked: cover property (state_ff == dsi_pkg::ST_RD_ACK &&
      acked_ff && scl_fall);
   c_read_nacked: cover property (state_ff == dsi_pkg::ST_RD_ACK &&
      !acked_ff && scl_fall);
   c_write_second: cover property (wr_commit &&
      shift_ff[dsi_pkg::SEL_BIT]);

endmodule

// [include/dsi_pkg.sv]
package dsi_pkg;

   // ***************************************************************
   // Target addressing and byte layout
   // ***************************************************************
   // Seven-bit target address with the select pin low and high.
   localparam logic [6:0] ADDR_PIN_LOW = 7'h08;
   localparam logic [6:0] ADDR_PIN_HIGH = 7'h09;
   // Bit of the written or read byte that picks the system register.
   localparam int SEL_BIT = 7;
   // Stored configuration fields of the two system registers.
   localparam int CFG1_W = 6;
   localparam int CFG1_LSB = 1;
   localparam int CFG2_W = 5;
   localparam int CFG2_LSB = 2;
   // Live status bit positions in the read byte.
   localparam int OVL_BIT = 0;
   localparam int OTEMP_BIT = 1;
   // Bit counter value of the last bit of a byte.
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [5:0] CFG1_RST = 6'h00;
   localparam logic [4:0] CFG2_RST = 5'h00;

   // ***************************************************************
   // Synchronised pin vector
   // ***************************************************************
   localparam int PIN_W = 7;
   localparam int PIN_SCL = 0;
   localparam int PIN_SDA = 1;
   localparam int PIN_GOOD = 2;
   localparam int PIN_ASEL = 3;
   localparam int PIN_OVL1 = 4;
   localparam int PIN_OVL2 = 5;
   localparam int PIN_OTEMP = 6;
   // Idle level of each pin: clock and data rest high on the pull-up.
   // Resetting the synchronisers to it avoids false bus edges at release.
   localparam logic [PIN_W-1:0] PIN_IDLE = 7'h03;

   // ***************************************************************
   // Software register port and interrupt events
   // ***************************************************************
   localparam logic [1:0] REG_CFG1 = 2'h0;
   localparam logic [1:0] REG_CFG2 = 2'h1;
   localparam logic [1:0] REG_STATUS = 2'h2;
   localparam logic [1:0] REG_MASK = 2'h3;
   localparam int EVT_W = 4;
   localparam int EVT_OVL1 = 0;
   localparam int EVT_OVL2 = 1;
   localparam int EVT_OTEMP = 2;
   localparam int EVT_WRITE = 3;
   localparam logic [3:0] EVT_RST = 4'h0;

   // Serial engine states, one-hot.
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_ADDR = 8'h02,
      ST_ADDR_ACK = 8'h04,
      ST_WR_DATA = 8'h08,
      ST_WR_ACK = 8'h10,
      ST_RD_DATA = 8'h20,
      ST_RD_ACK = 8'h40,
      ST_IGNORE = 8'h80
   } dsi_state_t;

endpackage

// [include/dsi_core_if.sv]
`timescale 1ns/1ps
interface dsi_core_if;
   logic [dsi_pkg::PIN_W-1:0] pin_raw;
   logic [dsi_pkg::PIN_W-1:0] pin_sync;
   logic [dsi_pkg::EVT_W-1:0] evt;
   logic [dsi_pkg::EVT_W-1:0] status;
   logic [dsi_pkg::EVT_W-1:0] mask;
   logic [dsi_pkg::EVT_W-1:0] mask_wdata;
   logic stat_clr;
   logic mask_wr;

   modport syn (input pin_raw, output pin_sync);
   modport core (output pin_raw, input pin_sync, output evt,
      output stat_clr, output mask_wr, output mask_wdata,
      input status, input mask);
   modport irq (input evt, input stat_clr, input mask_wr,
      input mask_wdata, output status, output mask);
endinterface

// [verilog/dsi_sync.sv]
`timescale 1ns/1ps
module dsi_sync (
   input wire logic mclk, // System clock.
   input wire logic srst, // Synchronous reset, active high.
   dsi_core_if.syn pins // Raw pins in, synchronised pins out.
);

   // ***************************************************************
   // Two-stage synchronisers
   // ***************************************************************
   // The first stage feeds only the second, so metastability settles
   // before any decoding logic sees the level.
   genvar gi;
   generate
      for (gi = 0; gi < dsi_pkg::PIN_W; gi++) begin : g_bit
         logic meta_ff;
         logic stab_ff;
         always_ff @(posedge mclk) begin
            if (srst) begin
               meta_ff <= dsi_pkg::PIN_IDLE[gi];
               stab_ff <= dsi_pkg::PIN_IDLE[gi];
            end else begin
               meta_ff <= pins.pin_raw[gi];
               stab_ff <= meta_ff;
            end
         end
         assign pins.pin_sync[gi] = stab_ff;
      end
   endgenerate

endmodule

// [verilog/dsi_irq.sv]
`timescale 1ns/1ps
module dsi_irq (
   input wire logic mclk, // System clock.
   input wire logic srst, // Synchronous reset, active high.
   dsi_core_if.irq ev, // Events, clear and mask write.
   output logic irq // Level interrupt, active high.
);

   logic [dsi_pkg::EVT_W-1:0] status_ff;
   logic [dsi_pkg::EVT_W-1:0] mask_ff;

   // Sticky status; a new event in the clearing cycle survives.
   always_ff @(posedge mclk) begin
      if (srst) begin
         status_ff <= dsi_pkg::EVT_RST;
      end else if (ev.stat_clr) begin
         status_ff <= ev.evt;
      end else begin
         status_ff <= status_ff | ev.evt;
      end
   end

   // Mask register, one enable per status bit.
   always_ff @(posedge mclk) begin
      if (srst) begin
         mask_ff <= dsi_pkg::EVT_RST;
      end else if (ev.mask_wr) begin
         mask_ff <= ev.mask_wdata;
      end
   end

   assign ev.status = status_ff;
   assign ev.mask = mask_ff;
   assign irq = |(status_ff & mask_ff);

   a_event_sticky: assert property (@(posedge mclk) disable iff (srst)
      (|ev.evt) |=> ((status_ff & $past(ev.evt)) == $past(ev.evt)))
      else $error("event lost from status");

endmodule

// [tb/dsi_master.sv]
`timescale 1ns/1ps
// ***************************************************************
// Serial bus master model
// ***************************************************************
module dsi_master (
   input wire logic mclk, // System clock.
   input wire logic sda, // Resolved data line, pulled up.
   output logic scl, // Serial clock, stands high outside frames.
   output logic sda_low // High while the master pulls data low.
);
   // Both lines idle released until the first frame.
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Lines move only just after an edge, so waits count whole cycles.
   task automatic w(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Data falls while the clock is high; also serves a repeated start.
   task automatic start();
      w(1);
      sda_low <= 1'b0;
      w(2);
      scl <= 1'b1;
      w(4);
      sda_low <= 1'b1;
      w(4);
      scl <= 1'b0;
   endtask
   // Data rises while the clock is high.
   task automatic stop();
      w(1);
      sda_low <= 1'b1;
      w(2);
      scl <= 1'b1;
      w(4);
      sda_low <= 1'b0;
      w(4);
   endtask
   // One 160 ns clock; data set mid-low, sampled mid-high.
   task automatic bit1(input logic b, output logic r);
      w(2);
      sda_low <= ~b;
      w(2);
      scl <= 1'b1;
      w(2);
      r = sda;
      w(2);
      scl <= 1'b0;
   endtask
   // Eight bits most significant first, then the ninth clock.
   task automatic xfer(input logic [7:0] d, input logic last,
      output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit1(d[i], r);
         q[i] = r;
      end
      bit1(last, r);
      ack = ~r;
   endtask
endmodule

// [tb/tb_dual_supply_i2c_status_port.sv]
`timescale 1ns/1ps
// ***************************************************************
// Bench for the dual supply status port
// ***************************************************************
module tb_dual_supply_i2c_status_port;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic supply_good = 1'b0;
   logic addr_sel = 1'b0;
   logic ovl1 = 1'b0, ovl2 = 1'b0, otemp = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [5:0] cfg_one, mcfg1 = 6'h00;
   logic [4:0] cfg_two, mcfg2 = 5'h00;
   logic [7:0] reg_rdata, d;
   logic irq, sda_out, sda_oe, scl, sda_low, sda, sel = 1'b0;
   logic [6:0] a;
   int bad_count = 0, checks = 0, cyc = 0;
   integer seed = 32'h4bfc;

   // Clock and the pulled-up open-drain data line.
   always #10 mclk = ~mclk;
   assign sda = ~(sda_low | (sda_oe & ~sda_out));

   dsi_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
   dsi_top dut (.mclk(mclk), .srst(srst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .supply_good(supply_good),
      .addr_sel(addr_sel), .overload_one(ovl1), .overload_two(ovl2),
      .overtemp(otemp), .cfg_one(cfg_one), .cfg_two(cfg_two),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

   task automatic report_and_stop();
      if (bad_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Cuts a hang short; the whole run needs about 4500 cycles.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic chk(input string n, input logic [7:0] e,
      input logic [7:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // Read byte expected from the selected register and live flags.
   function automatic logic [7:0] exp_rd(input logic s);
      return s ? {1'b1, mcfg2, otemp, ovl2} : {1'b0, mcfg1, ovl1};
   endfunction
   // Register port: one-cycle strobes, read data in the next cycle.
   task automatic rwr(input logic [1:0] ra, input logic [7:0] wd);
      @(posedge mclk);
      reg_addr <= ra;
      reg_wdata <= wd;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rrd(input logic [1:0] ra, input logic [7:0] e,
      input string n);
      @(posedge mclk);
      reg_addr <= ra;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(n, e, reg_rdata);
   endtask
   // Serial write of one byte; the model follows only if it is taken.
   task automatic iwr(input logic [6:0] ta, input logic [7:0] wd,
      input logic ok);
      logic [7:0] q;
      logic ak;
      m.start();
      m.xfer({ta, 1'b0}, 1'b1, q, ak);
      chk("addr ack", {7'h0, ok}, {7'h0, ak});
      if (ak === 1'b1) begin
         m.xfer(wd, 1'b1, q, ak);
         chk("data ack", 8'h01, {7'h0, ak});
      end
      m.stop();
      if (ok) begin
         sel = wd[7];
         if (wd[7]) mcfg2 = wd[6:2];
         else mcfg1 = wd[6:1];
      end
      chk("cfg one", {2'h0, mcfg1}, {2'h0, cfg_one});
      chk("cfg two", {3'h0, mcfg2}, {3'h0, cfg_two});
   endtask
   // Serial read: acknowledged byte, then a refused one, then release.
   task automatic ird(input logic [6:0] ta);
      logic [7:0] q;
      logic ak;
      m.start();
      m.xfer({ta, 1'b1}, 1'b1, q, ak);
      chk("read ack", 8'h01, {7'h0, ak});
      m.xfer(8'hFF, 1'b0, q, ak);
      chk("read byte", exp_rd(sel), q);
      m.xfer(8'hFF, 1'b1, q, ak);
      chk("next byte", exp_rd(sel), q);
      m.w(6);
      chk("released", 8'h00, {7'h0, sda_oe});
      m.stop();
   endtask

   // Main sequence; the lockout holds everything until supply is good.
   initial begin
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      iwr(7'h08, 8'h7E, 1'b0);
      supply_good <= 1'b1;
      repeat (10) @(posedge mclk);
      rrd(2'h2, 8'h00, "status idle");
      rwr(2'h3, 8'h00);
      iwr(7'h09, 8'h02, 1'b0);
      iwr(7'h08, 8'h7E, 1'b1);
      chk("irq masked", 8'h00, {7'h0, irq});
      rrd(2'h3, 8'h00, "mask");
      rwr(2'h3, 8'h08);
      #1 chk("irq raised", 8'h01, {7'h0, irq});
      rrd(2'h2, 8'h08, "status");
      chk("irq cleared", 8'h00, {7'h0, irq});
      rwr(2'h0, 8'hFF);
      rrd(2'h0, {2'h0, mcfg1}, "cfg ro");
      ird(7'h08);
      otemp <= 1'b1;
      // The flag needs two synchroniser stages and one status edge.
      repeat (3) @(posedge mclk);
      rwr(2'h3, 8'h04);
      #1 chk("irq temp", 8'h01, {7'h0, irq});
      rrd(2'h2, 8'h04, "status temp");
      // Random bytes on both addresses and both channels, random flags.
      for (int k = 0; k < 8; k++) begin
         addr_sel <= k[0];
         a = k[0] ? 7'h09 : 7'h08;
         d = 8'($random(seed));
         ovl1 <= 1'($random(seed));
         ovl2 <= 1'($random(seed));
         otemp <= 1'($random(seed));
         repeat (6) @(posedge mclk);
         iwr(a, d, 1'b1);
         ird(a);
      end
      // Lockout in mid-run clears both registers and the selection.
      supply_good <= 1'b0;
      repeat (6) @(posedge mclk);
      mcfg1 = 6'h00;
      mcfg2 = 5'h00;
      sel = 1'b0;
      iwr(7'h09, 8'hFE, 1'b0);
      supply_good <= 1'b1;
      repeat (10) @(posedge mclk);
      ird(7'h09);
      iwr(7'h09, 8'hFE, 1'b1);
      rrd(2'h1, {3'h0, mcfg2}, "cfg two rd");
      report_and_stop();
   end
endmodule
